// ---- hw/trgsel_map.vh ----
// register map, field positions, reset values and timing constants of the trigger selector
`ifndef TRGSEL_MAP_VH
`define TRGSEL_MAP_VH

// ==========================================================
// clock and timing
`define TRGSEL_CLK_MHZ 50
`define TRGSEL_PER_DEF_US 5000
`define TRGSEL_PER_DEF_CYC 40'h000003d090
`define TRGSEL_PER_MIN_NS 200
`define TRGSEL_PER_MIN_CYC 40'h000000000a
`define TRGSEL_REF_MHZ 10
`define TRGSEL_REF_WIN_US 10
`define TRGSEL_REF_WIN_CYC (`TRGSEL_REF_WIN_US * `TRGSEL_CLK_MHZ)
`define TRGSEL_REF_EDGES (`TRGSEL_REF_WIN_US * `TRGSEL_REF_MHZ)
`define TRGSEL_REF_TOL 6
`define TRGSEL_INT_DIV (`TRGSEL_CLK_MHZ / `TRGSEL_REF_MHZ)

// ==========================================================
// register byte offsets
`define TRGSEL_CTRL_OFF 12'h000
`define TRGSEL_LEVEL_OFF 12'h004
`define TRGSEL_PER_LO_OFF 12'h008
`define TRGSEL_PER_HI_OFF 12'h00c
`define TRGSEL_TRIG_OFF 12'h010
`define TRGSEL_STAT_OFF 12'h014

// ==========================================================
// control fields
`define TRGSEL_SRC_INT 2'h0
`define TRGSEL_SRC_EXT 2'h1
`define TRGSEL_SRC_MAN 2'h2
`define TRGSEL_SRC_BAD 2'h3
`define TRGSEL_CTRL_SLOPE 4
`define TRGSEL_CTRL_SEQ 8
`define TRGSEL_CTRL_SWP 9
`define TRGSEL_CTRL_TRG 10
`define TRGSEL_CTRL_GATE 11
`define TRGSEL_CTRL_SYNC 12
`define TRGSEL_LEVEL_MAX 8'sh64
`define TRGSEL_LEVEL_MIN (-8'sh64)
`define TRGSEL_PER_W 40

// ==========================================================
// reset values
`define TRGSEL_SLOPE_POS 1'b0
`define TRGSEL_LEVEL_RST 8'h00

`endif

// ---- hw/trgsel_tb_placeholder_none.v ----
// intentionally empty design unit list holder for build order
`timescale 1ns/1ps

// ---- hw/trgsel_top.v ----
// trigger source selector with reference detection and apb register access
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "trgsel_map.vh"
// Function
// - the source setting holds one of internal, external or manual, never two at once.
// - with internal source a programmable period generator (200 ns..10000 s) fires triggers.
// - with internal source the slope and threshold settings have no effect on triggers.
// - with internal or external source a manual key or bus trigger also fires a trigger.
// - with external source the slope-selected edge of the comparator input fires a trigger.
// - with manual source only the manual key or bus trigger fires, never the generator.
// - gated mode with external source and negative slope runs while the input is below level.
// - trigger events go to sequence advance, triggered sweep and triggered mode; gated mode follows the external input level.
// - the threshold is stored from -10.0 V to +10.0 V in 0.1 V steps and fed to the comparator.
// - reset loads internal source, 5 ms period, positive slope and zero level.
// - a valid 10 MHz signal on the reference input switches the reference to external.
// - the reference output carries the internal 10 MHz clock, or the external one if present.
// - with trigger sync chosen every trigger event, manual and bus included, makes a marker.
module trgsel_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire trig_cmp,
   input wire manual_trigger_key,
   input wire ref_in,
   output reg [7:0] level_code_q,
   output reg trig_pulse_q,
   output reg seq_adv_q,
   output reg sweep_trig_q,
   output reg mode_trig_q,
   output reg gate_run_q,
   output reg sync_marker_q,
   output reg ref_ext_q,
   output reg ref_out_q
);

   // ==========================================================
   // address decode
   // one decoder serves both the read mux and the write strobes
   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   // decides pslverr; every other offset is refused
   function mapped;
      input [11:0] addr;
      begin
         mapped = hit(addr, `TRGSEL_CTRL_OFF) | hit(addr, `TRGSEL_LEVEL_OFF) |
            hit(addr, `TRGSEL_PER_LO_OFF) | hit(addr, `TRGSEL_PER_HI_OFF) |
            hit(addr, `TRGSEL_TRIG_OFF) | hit(addr, `TRGSEL_STAT_OFF);
      end
   endfunction

   // ==========================================================
   // input synchronisers
   // both asynchronous pins pass two flops; stage one feeds stage two only
   wire [1:0] pin_raw;
   reg [1:0] sync1_q;
   reg [1:0] sync2_q;
   assign pin_raw = {ref_in, trig_cmp};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_q[gi] <= 1'b0;
               sync2_q[gi] <= 1'b0;
            end else begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   // one-cycle delayed copies for edge detection; the key pin is already synchronous
   reg cmp_d1_q;
   reg ref_d1_q;
   reg key_d1_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_d1_q <= 1'b0;
         ref_d1_q <= 1'b0;
         key_d1_q <= 1'b0;
      end else begin
         cmp_d1_q <= sync2_q[0];
         ref_d1_q <= sync2_q[1];
         key_d1_q <= manual_trigger_key;
      end
   end

   // ==========================================================
   // control registers
   reg [1:0] src_q;
   reg slope_q;
   reg [4:0] route_q; // seq, sweep, trig, gate, sync
   reg [7:0] level_q;
   reg [`TRGSEL_PER_W-1:0] period_q;
   reg bus_trig_q;
   reg [15:0] ev_cnt_q;

   // a write lands only in the access cycle that the slave acknowledges
   // the bus trigger is a strobe, so it reads back as zero
   wire acc;
   wire wr;
   assign acc = psel & penable & pready;
   assign wr = acc & pwrite;

   // level is signed tenths of a volt
   wire signed [7:0] wlevel;
   assign wlevel = pwdata[7:0];
   wire [`TRGSEL_PER_W-1:0] per_lo_d;
   wire [`TRGSEL_PER_W-1:0] per_hi_d;
   assign per_lo_d = {period_q[`TRGSEL_PER_W-1:32], pwdata};
   assign per_hi_d = {pwdata[`TRGSEL_PER_W-33:0], period_q[31:0]};

   // settings written by software; reset gives the power-on defaults
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_q <= `TRGSEL_SRC_INT;
         slope_q <= `TRGSEL_SLOPE_POS;
         level_q <= `TRGSEL_LEVEL_RST;
         period_q <= `TRGSEL_PER_DEF_CYC;
         route_q <= 5'h00;
         bus_trig_q <= 1'b0;
      end else begin
         bus_trig_q <= wr & hit(paddr, `TRGSEL_TRIG_OFF) & pwdata[0];
         if (wr & hit(paddr, `TRGSEL_CTRL_OFF)) begin
            // the unused code is refused so exactly one source stays active
            if (pwdata[1:0] != `TRGSEL_SRC_BAD)
               src_q <= pwdata[1:0];
            slope_q <= pwdata[`TRGSEL_CTRL_SLOPE];
            route_q <= pwdata[`TRGSEL_CTRL_SYNC:`TRGSEL_CTRL_SEQ];
         end
         // out-of-range levels are dropped, keeping the old threshold
         if (wr & hit(paddr, `TRGSEL_LEVEL_OFF) &&
            wlevel <= `TRGSEL_LEVEL_MAX && wlevel >= `TRGSEL_LEVEL_MIN)
            level_q <= pwdata[7:0];
         if (wr & hit(paddr, `TRGSEL_PER_LO_OFF))
            period_q <= (per_lo_d < `TRGSEL_PER_MIN_CYC) ?
               `TRGSEL_PER_MIN_CYC : per_lo_d;
         if (wr & hit(paddr, `TRGSEL_PER_HI_OFF))
            period_q <= (per_hi_d < `TRGSEL_PER_MIN_CYC) ?
               `TRGSEL_PER_MIN_CYC : per_hi_d;
      end
   end

   // ==========================================================
   // internal period generator
   // 40 bits reach 10000 s at 20 ns per cycle
   // limitation: periods below 10 cycles are clamped, so 200 ns is the floor
   reg [`TRGSEL_PER_W-1:0] per_cnt_q;
   wire per_tick;
   assign per_tick = (per_cnt_q >= period_q - 1'b1);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         per_cnt_q <= {`TRGSEL_PER_W{1'b0}};
      end else if (src_q != `TRGSEL_SRC_INT || per_tick) begin
         per_cnt_q <= {`TRGSEL_PER_W{1'b0}}; // restart keeps phase after source change
      end else begin
         per_cnt_q <= per_cnt_q + 1'b1;
      end
   end

   // ==========================================================
   // trigger event selection
   wire int_ev;
   wire ext_ev;
   wire man_ev;
   wire trig_ev;
   wire cmp_rise;
   wire cmp_fall;
   assign cmp_rise = sync2_q[0] & ~cmp_d1_q;
   assign cmp_fall = ~sync2_q[0] & cmp_d1_q;
   // slope and level never touch the internal path
   assign int_ev = (src_q == `TRGSEL_SRC_INT) & per_tick;
   // edges are seen two flops late: latency traded for metastability margin
   assign ext_ev = (src_q == `TRGSEL_SRC_EXT) &
      (slope_q ? cmp_fall : cmp_rise);
   // key and bus trigger act under every source
   assign man_ev = (manual_trigger_key & ~key_d1_q) | bus_trig_q;
   assign trig_ev = int_ev | ext_ev | man_ev;

   // gate runs while the input sits on the slope's active side
   wire gate_d;
   assign gate_d = route_q[3] & (src_q == `TRGSEL_SRC_EXT) &
      (slope_q ? ~sync2_q[0] : sync2_q[0]);

   // registered event fan-out, one clock per event
   // simultaneous events merge into one pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_pulse_q <= 1'b0;
         seq_adv_q <= 1'b0;
         sweep_trig_q <= 1'b0;
         mode_trig_q <= 1'b0;
         gate_run_q <= 1'b0;
         sync_marker_q <= 1'b0;
         level_code_q <= `TRGSEL_LEVEL_RST;
         ev_cnt_q <= 16'h0000;
      end else begin
         trig_pulse_q <= trig_ev;
         seq_adv_q <= trig_ev & route_q[0];
         sweep_trig_q <= trig_ev & route_q[1];
         mode_trig_q <= trig_ev & route_q[2];
         gate_run_q <= gate_d;
         sync_marker_q <= trig_ev & route_q[4];
         level_code_q <= level_q;
         if (trig_ev)
            ev_cnt_q <= ev_cnt_q + 16'h0001;
      end
   end

   // ==========================================================
   // reference detection
   // edges are counted over a fixed window; a lone glitch cannot switch over
   reg [9:0] win_cnt_q;
   reg [7:0] edge_cnt_q;
   wire win_end;
   wire ref_rise;
   assign win_end = (win_cnt_q == `TRGSEL_REF_WIN_CYC - 1);
   assign ref_rise = sync2_q[1] & ~ref_d1_q;
   // the edge count saturates so a fast input cannot wrap back into range
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_cnt_q <= 10'h000;
         edge_cnt_q <= 8'h00;
         ref_ext_q <= 1'b0;
      end else begin
         win_cnt_q <= win_end ? 10'h000 : win_cnt_q + 10'h001;
         if (win_end) begin
            edge_cnt_q <= {7'h00, ref_rise};
            ref_ext_q <= (edge_cnt_q >= `TRGSEL_REF_EDGES - `TRGSEL_REF_TOL) &&
               (edge_cnt_q <= `TRGSEL_REF_EDGES + `TRGSEL_REF_TOL);
         end else if (ref_rise && edge_cnt_q != 8'hff) begin
            edge_cnt_q <= edge_cnt_q + 8'h01;
         end
      end
   end

   // ==========================================================
   // reference output
   // internal 10 MHz is a divide-by-five, so its duty is 40/60
   reg [2:0] div_cnt_q;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_q <= 3'h0;
         ref_out_q <= 1'b0;
      end else begin
         div_cnt_q <= (div_cnt_q == `TRGSEL_INT_DIV - 1) ? 3'h0 : div_cnt_q + 3'h1;
         ref_out_q <= ref_ext_q ? sync2_q[1] :
            (div_cnt_q < `TRGSEL_INT_DIV / 2);
      end
   end

   // ==========================================================
   // apb slave
   // no wait state: data is looked up in setup and held through access
   // unmapped offsets read back as zero
   reg [31:0] rdata_d;
   always @* begin
      rdata_d = 32'h00000000;
      if (hit(paddr, `TRGSEL_CTRL_OFF))
         rdata_d = {19'h00000, route_q, 3'h0, slope_q, 2'h0, src_q};
      else if (hit(paddr, `TRGSEL_LEVEL_OFF))
         rdata_d = {24'h000000, level_q};
      else if (hit(paddr, `TRGSEL_PER_LO_OFF))
         rdata_d = period_q[31:0];
      else if (hit(paddr, `TRGSEL_PER_HI_OFF))
         rdata_d = {24'h000000, period_q[`TRGSEL_PER_W-1:32]};
      else if (hit(paddr, `TRGSEL_STAT_OFF))
         rdata_d = {ev_cnt_q, 13'h0000, gate_run_q, sync2_q[0], ref_ext_q};
   end

   // response launched in setup so pready stands for exactly the access cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel & ~penable) begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h00000000 : rdata_d;
         pslverr <= ~mapped(paddr);
      end else begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end
   end

endmodule

// ---- tb/trgsel_far_end.sv ----
// model of the trigger comparator and the external reference source
`timescale 1ns/1ps
module trgsel_far_end (
   input wire ref_on,
   input wire cmp_level,
   output logic trig_cmp,
   output logic ref_in
);
   // comparator output follows the level the bench applies
   assign trig_cmp = cmp_level;
   // 10 mhz source, parked low when absent so no stale edge is counted
   initial begin
      ref_in = 1'b0;
      #7;
      forever begin
         #50 ref_in = ref_on ? ~ref_in : 1'b0;
      end
   end
endmodule

// ---- tb/trgsel_properties.sv ----
// assertion checker for the trigger selector outputs
`timescale 1ns/1ps
module trgsel_chk (
   input wire pclk,
   input wire presetn,
   input wire manual_trigger_key,
   input wire [7:0] level_code_q,
   input wire trig_pulse_q,
   input wire seq_adv_q,
   input wire sweep_trig_q,
   input wire mode_trig_q,
   input wire sync_marker_q,
   input wire ref_ext_q,
   input wire ref_out_q
);
   // ==========================================
   // trigger events and their routes
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_trig_one_cycle: assert property (trig_pulse_q |=> !trig_pulse_q)
      else $error("trigger pulse wider than one cycle");
   a_key_fires: assert property ($rose(manual_trigger_key) |-> ##[1:2] trig_pulse_q)
      else $error("key press gave no trigger");
   a_seq_route: assert property (seq_adv_q |-> trig_pulse_q)
      else $error("sequence advance without trigger");
   a_sweep_route: assert property (sweep_trig_q |-> trig_pulse_q)
      else $error("sweep trigger without trigger");
   a_mode_route: assert property (mode_trig_q |-> trig_pulse_q)
      else $error("mode trigger without trigger");
   a_sync_mark: assert property (sync_marker_q |-> trig_pulse_q)
      else $error("sync marker without trigger");
   a_level_range: assert property ($signed(level_code_q) >= -100
      && $signed(level_code_q) <= 100)
      else $error("threshold outside range");
   // ==========================================
   // reference output: div5 when internal, live clock when external
   // the divider phase is only known once two cycles have passed without external
   a_ref_int_div: assert property ($rose(ref_out_q) && !ref_ext_q
      && !$past(ref_ext_q) && !$past(ref_ext_q, 2) |=> ref_out_q ##1 !ref_out_q)
      else $error("internal reference shape wrong");
   a_ref_ext_live: assert property (ref_ext_q && ref_out_q |-> ##[1:4] !ref_out_q)
      else $error("external reference not passed");
   c_key: cover property ($rose(manual_trigger_key) ##[1:2] trig_pulse_q);
   c_sync: cover property (sync_marker_q);
   c_ref: cover property ($rose(ref_ext_q));
endmodule
bind trgsel_top trgsel_chk u_chk (.pclk(pclk), .presetn(presetn),
   .manual_trigger_key(manual_trigger_key), .level_code_q(level_code_q),
   .trig_pulse_q(trig_pulse_q), .seq_adv_q(seq_adv_q), .sweep_trig_q(sweep_trig_q),
   .mode_trig_q(mode_trig_q), .sync_marker_q(sync_marker_q), .ref_ext_q(ref_ext_q),
   .ref_out_q(ref_out_q));

// ---- tb/trgsel_top_tb.sv ----
// self-checking bench for the trigger selector
`timescale 1ns/1ps
`include "trgsel_map.vh"
module trgsel_top_tb;
   logic pclk, presetn, psel, penable, pwrite, key, ref_on, cmp_lvl, rerr;
   logic [11:0] paddr;
   logic [31:0] pwdata, rdat, npulse, n0, nrt, r0;
   wire [31:0] prdata;
   wire [7:0] lvl;
   wire pready, pslverr, trig_cmp, ref_in, trg, ref_ext, gate, seq, swp, mtrg, smk;
   int err_total, num_checks, cyc;
   trgsel_top u_trgsel_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .trig_cmp(trig_cmp),
      .manual_trigger_key(key), .ref_in(ref_in), .level_code_q(lvl), .trig_pulse_q(trg),
      .seq_adv_q(seq), .sweep_trig_q(swp), .mode_trig_q(mtrg), .gate_run_q(gate),
      .sync_marker_q(smk), .ref_ext_q(ref_ext), .ref_out_q());
   trgsel_far_end u_trgsel_far_end (.ref_on(ref_on), .cmp_level(cmp_lvl),
      .trig_cmp(trig_cmp), .ref_in(ref_in));
   // ==========================================
   // clock, pulse counter and hang limit
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (trg === 1'b1) npulse <= npulse + 1;
      // all four consumers must see the pulse together
      if ({seq, swp, mtrg, smk} === 4'hf) nrt <= nrt + 1;
      if (cyc == 30000) begin
         err_total++;
         complete_run();
      end
   end
   // ==========================================
   // helpers
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // one apb transfer; holds everything until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no fixed latency assumed; only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
      chk({31'h0, rerr}, {31'h0, ee});
   endtask
   task mark;
      n0 = npulse;
      r0 = nrt;
   endtask
   task since(input int c, input logic [31:0] e, input logic [31:0] er);
      repeat (c) @(posedge pclk);
      chk(npulse - n0, e);
      chk(nrt - r0, er);
   endtask
   task press;
      key <= 1'b1;
      repeat (4) @(posedge pclk);
      key <= 1'b0;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ==========================================
   // main sequence
   initial begin
      int n;
      {psel, penable, pwrite, paddr, pwdata, key, ref_on, cmp_lvl, presetn} = '0;
      err_total = 0; num_checks = 0; cyc = 0; npulse = 0; n0 = 0; nrt = 0; r0 = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`TRGSEL_CTRL_OFF, 32'h0, 1'b0);
      rd(`TRGSEL_LEVEL_OFF, 32'h0, 1'b0);
      rd(`TRGSEL_PER_LO_OFF, 32'h0003d090, 1'b0);
      rd(`TRGSEL_PER_HI_OFF, 32'h0, 1'b0);
      rd(12'h020, 32'h0, 1'b1);
      apb(1'b1, `TRGSEL_LEVEL_OFF, 32'h64);
      apb(1'b1, `TRGSEL_LEVEL_OFF, 32'h65);
      rd(`TRGSEL_LEVEL_OFF, 32'h64, 1'b0);
      apb(1'b1, `TRGSEL_LEVEL_OFF, 32'h9c);
      // the level output is one flop behind the register
      @(posedge pclk);
      @(negedge pclk);
      chk({24'h0, lvl}, 32'h9c);
      // manual source with every route on; code 3 must not stick
      apb(1'b1, `TRGSEL_CTRL_OFF, 32'h1f02);
      apb(1'b1, `TRGSEL_CTRL_OFF, 32'h1f03);
      rd(`TRGSEL_CTRL_OFF, 32'h1f02, 1'b0);
      mark(); cmp_lvl <= 1'b1;
      since(10, 32'h0, 32'h0);
      cmp_lvl <= 1'b0; mark(); press();
      since(10, 32'h1, 32'h1);
      mark(); apb(1'b1, `TRGSEL_TRIG_OFF, 32'h1);
      since(10, 32'h1, 32'h1);
      rd(`TRGSEL_STAT_OFF, 32'h00020000, 1'b0);
      // routes off: the trigger still fires but reaches no consumer
      apb(1'b1, `TRGSEL_CTRL_OFF, 32'h0002);
      mark(); apb(1'b1, `TRGSEL_TRIG_OFF, 32'h1);
      since(10, 32'h1, 32'h0);
      // external, positive then negative slope, gate enabled
      apb(1'b1, `TRGSEL_CTRL_OFF, 32'h1f01);
      mark(); cmp_lvl <= 1'b1;
      since(10, 32'h1, 32'h1);
      mark(); cmp_lvl <= 1'b0;
      since(10, 32'h0, 32'h0);
      mark(); press();
      since(10, 32'h1, 32'h1);
      apb(1'b1, `TRGSEL_CTRL_OFF, 32'h1f11);
      mark(); cmp_lvl <= 1'b1;
      since(10, 32'h0, 32'h0);
      chk({31'h0, gate}, 32'h0);
      mark(); cmp_lvl <= 1'b0;
      since(10, 32'h1, 32'h1);
      chk({31'h0, gate}, 32'h1);
      // internal at the shortest period; slope and level must not matter
      apb(1'b1, `TRGSEL_PER_LO_OFF, 32'h5);
      rd(`TRGSEL_PER_LO_OFF, 32'h0000000a, 1'b0);
      apb(1'b1, `TRGSEL_CTRL_OFF, 32'h1f10);
      repeat (30) @(posedge pclk);
      mark();
      repeat (10) begin
         cmp_lvl <= ~cmp_lvl;
         repeat (10) @(posedge pclk);
      end
      since(0, 32'h0000000a, 32'h0000000a);
      // reference detection comes and goes by itself
      ref_on <= 1'b1;
      for (n = 0; n < 1200 && ref_ext !== 1'b1; n++) @(posedge pclk);
      chk({31'h0, ref_ext}, 32'h1);
      ref_on <= 1'b0;
      for (n = 0; n < 1200 && ref_ext !== 1'b0; n++) @(posedge pclk);
      chk({31'h0, ref_ext}, 32'h0);
      complete_run();
   end
endmodule
